// *** dv/lsfs_host_model.sv ***
// lsfs_host_model: host enable drive and pulled-up fault pins
// assumes one enable level for all switches; LOW_MASK marks active-low ones
`timescale 1ns/10ps
module lsfs_host_model #(
	parameter logic [2:0] LOW_MASK = 3'h1
) (
	// from the switches
	input  wire logic [2:0] faultOe,
	input  wire logic [2:0] faultOutN,
	// to the switches
	output logic      [2:0] enableIn,
	output logic      [2:0] faultPin
);
	logic hostOn = 1'b0;
	// pull-up wins while no switch pulls the line
	assign faultPin = faultOutN | ~faultOe;
	assign enableIn = {3{hostOn}} ^ LOW_MASK;
	task automatic set_en(input logic on);
		hostOn = on;
	endtask : set_en
endmodule : lsfs_host_model

// *** dv/lsfs_sequencer_sva.sv ***
// lsfs_sequencer_sva: port checks of the fault sequencer
// assumes bind to lsfs_sequencer; one tick is TICK_CYCLES clocks
`timescale 1ns/10ps
module lsfs_sequencer_sva #(
	parameter lsfs_pkg::lsfs_opt_t OPTION      = lsfs_pkg::LSFS_OPT_AUTORETRY,
	parameter bit                  EN_ACT_LOW  = 1'b0,
	parameter int                  QUAL_TICKS  = 5,
	parameter int                  RETRY_TICKS = 20
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// inputs
	input wire logic enableIn,
	input wire logic overCurrent,
	input wire logic overTemp,
	input wire logic reverseTrip,
	input wire logic limitSetPinGnd,
	// outputs
	input wire logic switchOn,
	input wire logic faultOe
);
	// slack covers the partial first tick of each delay
	localparam int TC   = lsfs_pkg::TICK_CYCLES;
	localparam int QMIN = (QUAL_TICKS - 1) * TC - 4;
	localparam int QMAX = QUAL_TICKS * TC + 4;
	localparam int RMIN = (RETRY_TICKS - 1) * TC;
	localparam int RMAX = RETRY_TICKS * TC + 4;
	wire hard = overTemp | reverseTrip | limitSetPinGnd;
	wire enOn = enableIn ^ EN_ACT_LOW;
	int  ocCnt_r;
	int  offCnt_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ocCnt_r  <= 0;
			offCnt_r <= 0;
		end else begin
			ocCnt_r  <= (overCurrent && switchOn) ? ocCnt_r + 1 : 0;
			offCnt_r <= (faultOe && !switchOn && !hard) ? offCnt_r + 1 : 0;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_qual_min; $rose(faultOe) && !hard && !$past(hard) |-> ocCnt_r >= QMIN; endproperty
	a_qual_min: assert property (p_qual_min) else $error("early fault");
	property p_qual_max; ocCnt_r >= QMAX |-> faultOe || !switchOn; endproperty
	a_qual_max: assert property (p_qual_max) else $error("late fault");
	property p_retry_min; $rose(switchOn) && offCnt_r > 3 |-> offCnt_r >= RMIN; endproperty
	a_retry_min: assert property (p_retry_min) else $error("short retry");
	property p_retry_max; offCnt_r >= RMAX |-> OPTION != lsfs_pkg::LSFS_OPT_AUTORETRY || !enOn;
	endproperty
	a_retry_max: assert property (p_retry_max) else $error("no restart");
	property p_auto_flag;
		OPTION == lsfs_pkg::LSFS_OPT_AUTORETRY && offCnt_r > 3 && enOn && !switchOn |=> faultOe;
	endproperty
	a_auto_flag: assert property (p_auto_flag) else $error("flag dropped");
	property p_latch;
		OPTION == lsfs_pkg::LSFS_OPT_LATCHOFF && offCnt_r > 3 && enOn |=> !switchOn && faultOe;
	endproperty
	a_latch: assert property (p_latch) else $error("latch lost");
	property p_cont_on;
		OPTION == lsfs_pkg::LSFS_OPT_CONTINUOUS && switchOn && enOn && !hard |=> switchOn;
	endproperty
	a_cont_on: assert property (p_cont_on) else $error("switch dropped");
	property p_hard; hard |=> !switchOn && faultOe; endproperty
	a_hard: assert property (p_hard) else $error("trip missed");
	property p_en_off; !enOn |=> !switchOn; endproperty
	a_en_off: assert property (p_en_off) else $error("on while disabled");
	c_fault: cover property ($rose(faultOe));
	c_retry: cover property ($rose(switchOn) && offCnt_r > 3);
	c_hard: cover property (hard);
endmodule : lsfs_sequencer_sva

bind lsfs_sequencer lsfs_sequencer_sva #(
	.OPTION(OPTION), .EN_ACT_LOW(EN_ACT_LOW),
	.QUAL_TICKS(QUAL_TICKS), .RETRY_TICKS(RETRY_TICKS)
) u_sva (
	.sys_clk(sys_clk), .rst(rst), .enableIn(enableIn), .overCurrent(overCurrent),
	.overTemp(overTemp), .reverseTrip(reverseTrip), .limitSetPinGnd(limitSetPinGnd),
	.switchOn(switchOn), .faultOe(faultOe)
);

// *** dv/lsfs_sequencer_tb.sv ***
// lsfs_sequencer_tb: the three options side by side on shared stimulus
// assumes short timers; bit 0 autoretry active-low, 1 latch-off, 2 continuous
`timescale 1ns/10ps
module lsfs_sequencer_tb;
	localparam int QT = 5;
	localparam int RT = 20;
	localparam int TC = lsfs_pkg::TICK_CYCLES;
	logic        sys_clk;
	logic        rst;
	logic        oc;
	logic [2:0]  hardv;
	logic [2:0]  en, sw, lim, pin, fo, oe;
	logic [31:0] seed = 32'h1b107078;
	logic [31:0] r;
	int          n_errors = 0;
	int          n_tests = 0;
	lsfs_host_model #(.LOW_MASK(3'h1)) host (
		.faultOe(oe), .faultOutN(fo), .enableIn(en), .faultPin(pin));
	for (genvar g = 0; g < 3; g++) begin : gOpt
		lsfs_sequencer #(.OPTION(lsfs_pkg::lsfs_opt_t'(g)), .EN_ACT_LOW(g == 0),
			.QUAL_TICKS(QT), .RETRY_TICKS(RT)) dut (
			.sys_clk(sys_clk), .rst(rst), .enableIn(en[g]), .overCurrent(oc),
			.overTemp(hardv[0]), .reverseTrip(hardv[1]), .limitSetPinGnd(hardv[2]),
			.switchOn(sw[g]), .limitActive(lim[g]), .faultInN(pin[g]),
			.faultOutN(fo[g]), .faultOe(oe[g]));
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// switch states per option: in retry or latched, continuous stays on
	function automatic logic [2:0] sw_exp(input bit inRetry, input bit latched);
		return {1'b1, !latched, !inRetry};
	endfunction : sw_exp
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic [2:0] s, input logic [2:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic close_out();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_errors++;
		close_out();
	end
	initial begin
		oc = 1'b0;
		hardv = 3'h0;
		rst = 1'b1;
		cyc(4);
		chk("switch", sw, 3'h0);
		chk("flag", pin, 3'h7);
		cyc(4);
		rst = 1'b0;
		cyc(1);
		host.set_en(1'b1);
		cyc(2);
		chk("switch", sw, sw_exp(0, 0));
		// overloads shorter than qualification never add up
		for (int i = 0; i < 4; i++) begin
			oc = 1'b1;
			cyc(50 + rnd() % 300);
			oc = 1'b0;
			cyc(2);
		end
		chk("flag", pin, 3'h7);
		oc = 1'b1;
		cyc(QT * TC + 10);
		chk("switch", sw, sw_exp(1, 1));
		chk("flag", pin, 3'h0);
		chk("limit", lim, 3'h4);
		cyc(1740);
		chk("switch", sw, sw_exp(1, 1));
		oc = 1'b0;
		cyc(350);
		chk("switch", sw, sw_exp(0, 1));
		chk("flag", pin, 3'h5);
		host.set_en(1'b0);
		cyc(3);
		chk("switch", sw, 3'h0);
		host.set_en(1'b1);
		cyc(3);
		chk("switch", sw, 3'h7);
		chk("flag", pin, 3'h7);
		for (int i = 0; i < 3; i++) begin
			hardv = 3'h1 << i;
			cyc(2);
			chk("switch", sw | pin, 3'h0);
			hardv = 3'h0;
			cyc(3);
			chk("flag", pin & sw, 3'h7);
		end
		for (int i = 0; i < 20; i++) begin
			r = rnd();
			hardv = r[2:0];
			oc = r[3];
			cyc(1 + int'(r[11:4]));
			hardv = 3'h0;
			oc = 1'b0;
			cyc(1);
		end
		cyc(4);
		chk("flag", pin & sw, 3'h7);
		close_out();
	end
endmodule : lsfs_sequencer_tb

// *** hdl/lsfs_pkg.sv ***
// lsfs_pkg: constants and types shared by the load-switch fault sequencer.
// assumes a 100 MHz system clock; the delays are converted to microsecond tick counts here.
package lsfs_pkg;

	// ------------------------------------------------------------------
	// clock and delays
	// ------------------------------------------------------------------
	localparam int  CLK_PERIOD_NS   = 10;
	localparam real QUAL_TIME_MS    = 17.5;
	localparam real RETRY_TIME_MS   = 560.0;
	// one shared timebase tick per microsecond keeps both delays in fixed ratio
	localparam int  TICK_TIME_NS    = 1000;
	localparam int  TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int  QUAL_TICKS      = int'(QUAL_TIME_MS * 1000.0);
	localparam int  RETRY_TICKS     = int'(RETRY_TIME_MS * 1000.0);
	localparam int  TIMER_W         = 20;
	localparam int  TICK_W          = 8;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [TIMER_W-1:0] TIMER_RST = 20'h00000;
	localparam logic [TICK_W-1:0]  TICK_RST  = 8'h00;

	// ------------------------------------------------------------------
	// build options and states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		LSFS_OPT_AUTORETRY  = 2'b00,
		LSFS_OPT_LATCHOFF   = 2'b01,
		LSFS_OPT_CONTINUOUS = 2'b10
	} lsfs_opt_t;

	typedef enum logic [2:0] {
		LSFS_ST_OFF     = 3'b000,
		LSFS_ST_ON      = 3'b001,
		LSFS_ST_QUAL    = 3'b010,
		LSFS_ST_RETRY   = 3'b011,
		LSFS_ST_LATCHED = 3'b100,
		LSFS_ST_LIMIT   = 3'b101
	} lsfs_state_t;

endpackage : lsfs_pkg

// *** hdl/lsfs_sequencer.sv ***
// lsfs_sequencer: enable, overcurrent qualification and fault sequencing of a
// current-limited load switch, with an open-drain active-low fault indicator.
// assumes analog detectors deliver clean levels synchronous to sys_clk; the
// analog limiter itself clamps current whenever limitActive is high.
//
// Functional notes
// - overcurrent starts the qualification timer
// - overcurrent gone early clears the timer
// - qualified limit flags fault, then per option
// - autoretry holds switch off for retry delay
// - retry end turns switch on again
// - fault stays asserted through autoretry cycling
// - qualify 17.5 ms, retry 560 ms
// - latch-off keeps switch off after qualification
// - enable toggle clears latched fault
// - continuous keeps switch on, flags while limiting
// - over-temperature trips switch off and flags
// - thermal restart after hysteresis drop
// - enable polarity per variant
// - reverse current trips switch off immediately
// - reverse trip released when detector clears
// - fault on qualify, reverse, thermal, grounded pin
// - fault is active-low open drain
// - grounded limit pin keeps switch off, except one cycle at autoretry retry end
// - both delays from one shared timebase
`timescale 1ns/10ps
module lsfs_sequencer #(
	parameter lsfs_pkg::lsfs_opt_t OPTION     = lsfs_pkg::LSFS_OPT_AUTORETRY,
	parameter bit                  EN_ACT_LOW = 1'b0,
	parameter int                  QUAL_TICKS  = lsfs_pkg::QUAL_TICKS,
	parameter int                  RETRY_TICKS = lsfs_pkg::RETRY_TICKS
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// host side
	input  wire logic enableIn,
	// analog detectors
	input  wire logic overCurrent,
	input  wire logic overTemp,
	input  wire logic reverseTrip,
	input  wire logic limitSetPinGnd,
	// power switch control
	output logic      switchOn,
	output logic      limitActive,
	// open-drain fault indicator, active low
	input  wire logic faultInN,
	output logic      faultOutN,
	output logic      faultOe
);

	// ------------------------------------------------------------------
	// shared timebase
	// ------------------------------------------------------------------
	logic tick;

	lsfs_timebase u_tb (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tick    (tick)
	);

	// ------------------------------------------------------------------
	// enable decode
	// ------------------------------------------------------------------
	wire enReq;

	// a toggle of the pin is an off phase followed by on; the off phase alone
	// is enough to leave the latched state
	assign enReq  = EN_ACT_LOW ? ~enableIn : enableIn;

	// ------------------------------------------------------------------
	// immediate trips
	// ------------------------------------------------------------------
	wire hardTrip;

	// thermal and reverse hysteresis live in the analog detectors; the
	// digital side simply follows their levels
	assign hardTrip = overTemp | reverseTrip | limitSetPinGnd;

	// ------------------------------------------------------------------
	// state and timer
	// ------------------------------------------------------------------
	lsfs_pkg::lsfs_state_t       state_r;
	lsfs_pkg::lsfs_state_t       state_nxt;
	logic [lsfs_pkg::TIMER_W-1:0] timer_r;
	logic [lsfs_pkg::TIMER_W-1:0] timer_nxt;
	logic                         faultQual_r;
	logic                         faultQual_nxt;
	logic                         faultOut_r;

	function automatic logic [lsfs_pkg::TIMER_W-1:0] tickInc(
		input logic [lsfs_pkg::TIMER_W-1:0] t,
		input logic                         tk
	);
		tickInc = tk ? t + 20'h00001 : t;
	endfunction : tickInc

	function automatic logic reached(
		input logic [lsfs_pkg::TIMER_W-1:0] t,
		input int                           lim
	);
		reached = (t >= lsfs_pkg::TIMER_W'(lim));
	endfunction : reached

	wire qualDone;
	wire retryDone;

	assign qualDone  = reached(timer_r, QUAL_TICKS);
	assign retryDone = reached(timer_r, RETRY_TICKS);

	always_comb begin
		state_nxt     = state_r;
		timer_nxt     = timer_r;
		faultQual_nxt = faultQual_r;
		case (state_r)
			lsfs_pkg::LSFS_ST_OFF: begin
				timer_nxt     = lsfs_pkg::TIMER_RST;
				faultQual_nxt = 1'b0;
				if (enReq && !hardTrip)
					state_nxt = lsfs_pkg::LSFS_ST_ON;
			end
			lsfs_pkg::LSFS_ST_ON: begin
				timer_nxt = lsfs_pkg::TIMER_RST;
				if (!enReq || hardTrip) begin
					state_nxt = lsfs_pkg::LSFS_ST_OFF;
				end else if (overCurrent) begin
					state_nxt = lsfs_pkg::LSFS_ST_QUAL;
				end else begin
					faultQual_nxt = 1'b0;
				end
			end
			lsfs_pkg::LSFS_ST_QUAL: begin
				timer_nxt = tickInc(timer_r, tick);
				if (!enReq || hardTrip) begin
					state_nxt = lsfs_pkg::LSFS_ST_OFF;
				end else if (!overCurrent) begin
					state_nxt = lsfs_pkg::LSFS_ST_ON;
					timer_nxt = lsfs_pkg::TIMER_RST;
				end else if (qualDone) begin
					faultQual_nxt = 1'b1;
					timer_nxt     = lsfs_pkg::TIMER_RST;
					case (OPTION)
						lsfs_pkg::LSFS_OPT_AUTORETRY:  state_nxt = lsfs_pkg::LSFS_ST_RETRY;
						lsfs_pkg::LSFS_OPT_LATCHOFF:   state_nxt = lsfs_pkg::LSFS_ST_LATCHED;
						lsfs_pkg::LSFS_OPT_CONTINUOUS: state_nxt = lsfs_pkg::LSFS_ST_LIMIT;
						default:                       state_nxt = lsfs_pkg::LSFS_ST_LATCHED;
					endcase
				end
			end
			lsfs_pkg::LSFS_ST_RETRY: begin
				timer_nxt = tickInc(timer_r, tick);
				if (!enReq) begin
					state_nxt = lsfs_pkg::LSFS_ST_OFF;
				end else if (retryDone) begin
					// fault flag is kept; it drops if the next on-phase is clean or enable is removed
					state_nxt = lsfs_pkg::LSFS_ST_ON;
					timer_nxt = lsfs_pkg::TIMER_RST;
				end
			end
			lsfs_pkg::LSFS_ST_LATCHED: begin
				timer_nxt = lsfs_pkg::TIMER_RST;
				if (!enReq)
					state_nxt = lsfs_pkg::LSFS_ST_OFF;
			end
			lsfs_pkg::LSFS_ST_LIMIT: begin
				timer_nxt = lsfs_pkg::TIMER_RST;
				if (!enReq || hardTrip) begin
					state_nxt = lsfs_pkg::LSFS_ST_OFF;
				end else if (!overCurrent) begin
					state_nxt     = lsfs_pkg::LSFS_ST_ON;
					faultQual_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt     = lsfs_pkg::LSFS_ST_OFF;
				timer_nxt     = lsfs_pkg::TIMER_RST;
				faultQual_nxt = 1'b0;
			end
		endcase
	end

	// in autoretry the on-phase after a retry keeps the flag until it runs clean;
	// a new overcurrent there keeps it asserted through the next qualification
	wire switchOnNxt;
	wire faultNxt;

	assign switchOnNxt = (state_nxt == lsfs_pkg::LSFS_ST_ON)
		| (state_nxt == lsfs_pkg::LSFS_ST_QUAL)
		| (state_nxt == lsfs_pkg::LSFS_ST_LIMIT);
	assign faultNxt    = faultQual_nxt | (hardTrip & state_nxt != lsfs_pkg::LSFS_ST_LATCHED)
		| (state_nxt == lsfs_pkg::LSFS_ST_LATCHED) | hardTrip;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r     <= lsfs_pkg::LSFS_ST_OFF;
			timer_r     <= lsfs_pkg::TIMER_RST;
			faultQual_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			timer_r     <= timer_nxt;
			faultQual_r <= faultQual_nxt;
		end
	end

	logic switchOn_r;
	logic limit_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			switchOn_r <= 1'b0;
			limit_r    <= 1'b0;
			faultOut_r <= 1'b0;
		end else begin
			switchOn_r <= switchOnNxt;
			limit_r    <= switchOnNxt & overCurrent;
			faultOut_r <= faultNxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign switchOn    = switchOn_r;
	assign limitActive = limit_r;
	// open drain: only ever drive low, release for the pull-up otherwise
	assign faultOutN   = 1'b0;
	assign faultOe     = faultOut_r;

endmodule : lsfs_sequencer

// *** hdl/lsfs_timebase.sv ***
// lsfs_timebase: free-running prescaler giving one tick per microsecond.
// assumes the system clock of the package; a single instance serves every timer.
`timescale 1ns/10ps
module lsfs_timebase (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// tick out
	output logic      tick
);

	logic [lsfs_pkg::TICK_W-1:0] count_r;
	logic [lsfs_pkg::TICK_W-1:0] count_nxt;
	wire                         wrap;

	assign wrap      = (count_r == lsfs_pkg::TICK_W'(lsfs_pkg::TICK_CYCLES - 1));
	assign count_nxt = wrap ? lsfs_pkg::TICK_RST : count_r + 8'h01;
	assign tick      = wrap;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			count_r <= lsfs_pkg::TICK_RST;
		else
			count_r <= count_nxt;
	end

endmodule : lsfs_timebase
